// ---- core/can_irq_power_mode_ctrl.sv ----
`include "can_irq_consts.svh"
module can_irq_power_mode_ctrl #(
  parameter int ERR_W = 9
) (
  // Clock and reset
  input wire logic CLK,
  input wire logic RESET,
  // APB slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // CPU state
  input wire logic CPU_STOP,
  // Protocol engine events
  input wire logic BIT_TICK,
  input wire logic EOF_DONE,
  input wire logic FRAME_ACCEPTED,
  input wire logic OWN_FRAME,
  input wire logic ENGINE_BUSY,
  input wire logic [2:0] TX_DONE,
  input wire logic [2:0] TX_ABORT_REQ,
  input wire logic RX_ERR_INC,
  input wire logic RX_ERR_DEC,
  input wire logic TX_ERR_INC,
  input wire logic TX_ERR_DEC,
  // CAN pins
  input wire logic CAN_RX,
  input wire logic ENGINE_TX,
  output logic CAN_TX,
  // Engine controls
  output logic ENGINE_HALT,
  output logic ENGINE_CLK_EN,
  output logic [2:0] TX_PENDING,
  output logic COPY_FG,
  output logic BUSOFF_COUNT_EN,
  // Interrupt vectors and timer link
  output logic IRQ_WAKEUP,
  output logic IRQ_ERROR,
  output logic IRQ_RX,
  output logic IRQ_TX,
  output logic TIMER_LINK
);
  initial begin
    if (ERR_W < 9 || ERR_W > 32) $error("ERR_W must lie between 9 and 32");
  end

  ////////////////////////////////////////////////////////////////////////
  // Register state
  logic [7:0] ctrl0_q, ctrl1_q, btr0_q, btr1_q, acc_ctrl_q, rxien_q;
  logic [2:0] txe_q, txien_q;
  logic [7:0] rxflg_q;
  logic [7:0] accept_q [8];
  logic [ERR_W-1:0] rx_err_q, tx_err_q;
  logic bg_full_q, resync_q, tlink_q;
  logic [3:0] recess_q;
  can_irq_pkg::mode_t mode;
  logic soft_reset, sleep_req, sleep_ack, powered;
  logic wr, rd, cfg_ok;
  logic [7:0] w8;

  assign soft_reset = ctrl0_q[`CTRL0_SOFT_RESET];
  assign sleep_req = ctrl0_q[`CTRL0_SLEEP_REQ];
  assign sleep_ack = ctrl0_q[`CTRL0_SLEEP_ACK];
  assign w8 = PWDATA[7:0];

  // Mode decode; cpu stop overrides every bit
  always_comb begin
    if (CPU_STOP) begin
      mode = can_irq_pkg::MODE_PWRDN;
    end else if (sleep_ack && !soft_reset) begin
      mode = can_irq_pkg::MODE_SLEEP;
    end else if (soft_reset) begin
      mode = can_irq_pkg::MODE_SOFTRST;
    end else begin
      mode = can_irq_pkg::MODE_NORMAL;
    end
  end

  assign powered = (mode != can_irq_pkg::MODE_PWRDN);
  // Bus accesses are dropped entirely while powered down
  assign wr = PSEL && PENABLE && PWRITE && powered;
  assign rd = PSEL && !PWRITE && powered;
  assign cfg_ok = soft_reset;

  ////////////////////////////////////////////////////////////////////////
  // APB answer: zero wait states, error on unmapped or power-down
  logic mapped;
  always_comb begin
    unique case (PADDR)
      `OFF_CTRL0, `OFF_CTRL1, `OFF_BTR0, `OFF_BTR1, `OFF_RXFLG, `OFF_RXIEN,
      `OFF_TXFLG, `OFF_TXIEN, `OFF_ACC_CTRL, `OFF_RXERR, `OFF_TXERR,
      `OFF_STATUS: mapped = 1'b1;
      default: mapped = (PADDR[11:5] == `OFF_ACC_BASE >> 5 ||
                         PADDR[11:5] == `OFF_MASK_BASE >> 5) && PADDR[4] == 1'b0 &&
                        PADDR[1:0] == 2'b00;
    endcase
  end
  assign PREADY = 1'b1;
  assign PSLVERR = PSEL && PENABLE && (!mapped || !powered);

  // Read data registered in the setup cycle
  always_ff @(posedge CLK) begin
    if (RESET) begin
      PRDATA <= 32'h0000_0000;
    end else if (rd && !PENABLE) begin
      PRDATA <= 32'h0000_0000;
      unique case (PADDR)
        `OFF_CTRL0: PRDATA[7:0] <= ctrl0_q;
        `OFF_CTRL1: PRDATA[7:0] <= ctrl1_q;
        `OFF_BTR0: PRDATA[7:0] <= btr0_q;
        `OFF_BTR1: PRDATA[7:0] <= btr1_q;
        `OFF_RXFLG: PRDATA[7:0] <= rxflg_q;
        `OFF_RXIEN: PRDATA[7:0] <= rxien_q;
        `OFF_TXFLG: PRDATA[2:0] <= txe_q;
        `OFF_TXIEN: PRDATA[2:0] <= txien_q;
        `OFF_ACC_CTRL: PRDATA[7:0] <= acc_ctrl_q;
        `OFF_RXERR: PRDATA[ERR_W-1:0] <= rx_err_q;
        `OFF_TXERR: PRDATA[ERR_W-1:0] <= tx_err_q;
        `OFF_STATUS: PRDATA[3:0] <= {resync_q, bg_full_q, mode};
        default: begin
          // Codes sit in entries 0 to 3, masks in entries 4 to 7
          if (PADDR[11:5] == `OFF_ACC_BASE >> 5 && !PADDR[4]) begin
            PRDATA[7:0] <= accept_q[{1'b0, PADDR[3:2]}];
          end else if (PADDR[11:5] == `OFF_MASK_BASE >> 5 && !PADDR[4]) begin
            PRDATA[7:0] <= accept_q[{1'b1, PADDR[3:2]}];
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Configuration registers, writable only in soft reset
  always_ff @(posedge CLK) begin
    if (RESET) begin
      ctrl1_q <= 8'h00;
      btr0_q <= 8'h00;
      btr1_q <= 8'h00;
      acc_ctrl_q <= 8'h00;
    end else if (wr && cfg_ok) begin
      if (PADDR == `OFF_CTRL1) ctrl1_q <= w8;
      if (PADDR == `OFF_BTR0) btr0_q <= w8;
      if (PADDR == `OFF_BTR1) btr1_q <= w8;
      if (PADDR == `OFF_ACC_CTRL) acc_ctrl_q <= w8;
    end
  end

  // Acceptance code and mask bytes, one per loop entry
  for (genvar i = 0; i < 8; i++) begin : g_accept
    always_ff @(posedge CLK) begin
      if (RESET) begin
        accept_q[i] <= 8'h00;
      end else if (wr && cfg_ok && PADDR[4:2] == 3'(i % 4) &&
                   PADDR[11:5] == ((i < 4) ? `OFF_ACC_BASE >> 5 : `OFF_MASK_BASE >> 5)) begin
        accept_q[i] <= w8;
      end
    end
  end

  // Interrupt enables, writable in every mode but power-down
  always_ff @(posedge CLK) begin
    if (RESET) begin
      rxien_q <= 8'h00;
      txien_q <= 3'h0;
    end else if (wr) begin
      if (PADDR == `OFF_RXIEN) rxien_q <= w8;
      if (PADDR == `OFF_TXIEN) txien_q <= PWDATA[2:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Sleep handshake and soft reset control
  logic traffic, bus_active;
  assign traffic = ENGINE_BUSY || (|(~txe_q));
  assign bus_active = !CAN_RX;

  always_ff @(posedge CLK) begin
    if (RESET) begin
      ctrl0_q <= `CTRL0_RESET_VAL;
    end else begin
      if (wr && PADDR == `OFF_CTRL0) begin
        ctrl0_q[`CTRL0_SOFT_RESET] <= w8[`CTRL0_SOFT_RESET];
        ctrl0_q[`CTRL0_TLINK_EN] <= w8[`CTRL0_TLINK_EN];
        // Early clear of the request is refused
        if (w8[`CTRL0_SLEEP_REQ] || sleep_ack) begin
          ctrl0_q[`CTRL0_SLEEP_REQ] <= w8[`CTRL0_SLEEP_REQ];
        end
      end
      if (!sleep_ack) begin
        // Enter only once idle, finishing current traffic
        if (sleep_req && !soft_reset && !traffic && powered) begin
          ctrl0_q[`CTRL0_SLEEP_ACK] <= 1'b1;
        end
      end else if (bus_active || !sleep_req || soft_reset ||
                   (wr && PADDR == `OFF_CTRL0 &&
                    (!w8[`CTRL0_SLEEP_REQ] || w8[`CTRL0_SOFT_RESET]))) begin
        ctrl0_q[`CTRL0_SLEEP_ACK] <= 1'b0;
        if (bus_active) ctrl0_q[`CTRL0_SLEEP_REQ] <= 1'b0;
      end
    end
  end

  // Engine gating: clocks stop in sleep and power-down
  assign ENGINE_CLK_EN = (mode == can_irq_pkg::MODE_NORMAL);
  assign ENGINE_HALT = soft_reset || !powered;
  assign CAN_TX = (mode == can_irq_pkg::MODE_NORMAL) && !resync_q ? ENGINE_TX : 1'b1;
  // Recovery count runs only with the engine clocked; resumes on wakeup
  assign BUSOFF_COUNT_EN = rxflg_q[`RXF_BUSOFF] && ENGINE_CLK_EN;

  // Resynchronise after wakeup: wait for eleven recessive bits
  always_ff @(posedge CLK) begin
    if (RESET) begin
      resync_q <= 1'b0;
      recess_q <= 4'h0;
    end else if (sleep_ack && mode == can_irq_pkg::MODE_SLEEP) begin
      resync_q <= 1'b1;
      recess_q <= 4'h0;
    end else if (resync_q && BIT_TICK) begin
      if (!CAN_RX) begin
        recess_q <= 4'h0;
      end else if (recess_q == `RESYNC_BITS - 4'd1) begin
        resync_q <= 1'b0;
      end else begin
        recess_q <= recess_q + 4'd1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Error counters: only the protocol engine and soft reset move them
  logic running;
  assign running = ENGINE_CLK_EN && !soft_reset;
  always_ff @(posedge CLK) begin
    if (RESET || soft_reset) begin
      rx_err_q <= '0;
      tx_err_q <= '0;
    end else if (running) begin
      if (RX_ERR_INC && rx_err_q != '1) rx_err_q <= rx_err_q + 1'b1;
      else if (RX_ERR_DEC && rx_err_q != '0) rx_err_q <= rx_err_q - 1'b1;
      if (TX_ERR_INC && tx_err_q != '1) tx_err_q <= tx_err_q + 1'b1;
      else if (TX_ERR_DEC && tx_err_q != '0) tx_err_q <= tx_err_q - 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Receive path: background buffer and foreground copy
  logic rx_ok, copy_now, clr_rxf;
  logic [7:0] rx_cond, rx_set, rx_clr;
  assign rx_ok = running && !resync_q && EOF_DONE && FRAME_ACCEPTED && !OWN_FRAME;
  assign clr_rxf = wr && PADDR == `OFF_RXFLG;
  // Copy deferred while asleep; it runs on wakeup
  assign copy_now = bg_full_q && !rxflg_q[`RXF_FULL] && running;
  assign COPY_FG = copy_now;

  always_ff @(posedge CLK) begin
    if (RESET || soft_reset) begin
      bg_full_q <= 1'b0;
    end else if (rx_ok && !(bg_full_q && rxflg_q[`RXF_FULL])) begin
      bg_full_q <= 1'b1;
    end else if (copy_now) begin
      bg_full_q <= 1'b0;
    end
  end

  // Conditions that persist and events that set flags
  always_comb begin
    rx_cond = 8'h00;
    rx_cond[`RXF_RXWARN] = rx_err_q >= `WARN_LIMIT;
    rx_cond[`RXF_TXWARN] = tx_err_q >= `WARN_LIMIT;
    rx_cond[`RXF_RXPASS] = rx_err_q > `PASSIVE_LIMIT;
    rx_cond[`RXF_TXPASS] = tx_err_q > `PASSIVE_LIMIT;
    rx_cond[`RXF_BUSOFF] = tx_err_q > `BUSOFF_LIMIT;
    rx_set = rx_cond;
    rx_set[`RXF_FULL] = copy_now;
    rx_set[`RXF_OVERRUN] = rx_ok && bg_full_q && rxflg_q[`RXF_FULL];
    rx_set[`RXF_WAKEUP] = sleep_ack && bus_active && rxien_q[`RXF_WAKEUP];
    rx_clr = clr_rxf ? w8 : 8'h00;
  end

  // Write-one clears; a live condition or event wins
  always_ff @(posedge CLK) begin
    if (RESET) begin
      rxflg_q <= 8'h00;
    end else begin
      rxflg_q <= (rxflg_q & ~rx_clr) | rx_set;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Transmit buffers: empty flags; clearing schedules a buffer
  logic [2:0] tx_clr, tx_set;
  assign tx_clr = (wr && PADDR == `OFF_TXFLG) ? PWDATA[2:0] : 3'h0;
  // Aborts only take effect while the engine runs
  assign tx_set = (running ? (TX_DONE | TX_ABORT_REQ) : 3'h0) | (soft_reset ? 3'h7 : 3'h0);
  always_ff @(posedge CLK) begin
    if (RESET) begin
      txe_q <= 3'h7;
    end else begin
      txe_q <= (txe_q & ~tx_clr) | tx_set;
    end
  end
  // Transmissions requested during sleep wait for wakeup
  assign TX_PENDING = running ? ~txe_q : 3'h0;

  ////////////////////////////////////////////////////////////////////////
  // Interrupt vectors
  logic [7:0] rx_act;
  assign rx_act = rxflg_q & rxien_q;
  assign IRQ_WAKEUP = rx_act[`RXF_WAKEUP];
  assign IRQ_ERROR = |rx_act[6:1];
  assign IRQ_RX = rx_act[`RXF_FULL];
  assign IRQ_TX = |(txe_q & txien_q);

  // Timer link pulse lasts until the next bit tick after any frame end, own or accepted or not
  always_ff @(posedge CLK) begin
    if (RESET) begin
      tlink_q <= 1'b0;
    end else if (running && EOF_DONE && ctrl0_q[`CTRL0_TLINK_EN]) begin
      tlink_q <= 1'b1;
    end else if (BIT_TICK) begin
      tlink_q <= 1'b0;
    end
  end
  assign TIMER_LINK = tlink_q;
endmodule

// ---- core/can_irq_consts.svh ----
`ifndef CAN_IRQ_CONSTS_SVH
`define CAN_IRQ_CONSTS_SVH

// Register byte offsets on the APB window
`define OFF_CTRL0     12'h000
`define OFF_CTRL1     12'h004
`define OFF_BTR0      12'h008
`define OFF_BTR1      12'h00C
`define OFF_RXFLG     12'h010
`define OFF_RXIEN     12'h014
`define OFF_TXFLG     12'h018
`define OFF_TXIEN     12'h01C
`define OFF_ACC_CTRL  12'h020
`define OFF_RXERR     12'h024
`define OFF_TXERR     12'h028
`define OFF_ACC_BASE  12'h040
`define OFF_MASK_BASE 12'h060
`define OFF_STATUS    12'h080

// Control register 0 fields
`define CTRL0_SOFT_RESET 0
`define CTRL0_SLEEP_REQ  1
`define CTRL0_SLEEP_ACK  2
`define CTRL0_TLINK_EN   3
`define CTRL0_RESET_VAL  8'h01

// Receive flag register fields; enable register uses the same positions
`define RXF_FULL    0
`define RXF_OVERRUN 1
`define RXF_BUSOFF  2
`define RXF_TXPASS  3
`define RXF_RXPASS  4
`define RXF_TXWARN  5
`define RXF_RXWARN  6
`define RXF_WAKEUP  7

// Error counter limits
`define WARN_LIMIT    9'd96
`define PASSIVE_LIMIT 9'd127
`define BUSOFF_LIMIT  9'd255

// Recessive bits needed to resynchronise after wakeup
`define RESYNC_BITS 4'd11

`endif

// ---- core/can_irq_pkg.sv ----
package can_irq_pkg;
  // Operating mode of the controller
  typedef enum logic [1:0] {
    MODE_NORMAL = 2'b00,
    MODE_SLEEP = 2'b01,
    MODE_SOFTRST = 2'b10,
    MODE_PWRDN = 2'b11
  } mode_t;
endpackage

// ---- sim/can_irq_props.sv ----
module can_irq_props (
  // Clock and reset
  input logic CLK,
  input logic RESET,
  // Register bus
  input logic PSEL,
  input logic PENABLE,
  input logic PSLVERR,
  // Modes and engine
  input logic CPU_STOP,
  input logic BIT_TICK,
  input logic EOF_DONE,
  input logic ENGINE_HALT,
  input logic ENGINE_CLK_EN,
  input logic COPY_FG,
  input logic BUSOFF_COUNT_EN,
  input logic [2:0] TX_PENDING,
  input logic CAN_TX,
  // Requests and timer link
  input logic IRQ_TX,
  input logic IRQ_ERROR,
  input logic TIMER_LINK
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RESET);
  ////////////////////////////////////////
  // Low-power modes keep the bus safe
  AST_LP_TX: assert property (!ENGINE_CLK_EN |-> CAN_TX)
    else $error("tx pin not recessive while stopped");
  AST_STOP_HALT: assert property (CPU_STOP |-> ENGINE_HALT && !ENGINE_CLK_EN)
    else $error("engine runs in power-down");
  AST_STOP_ERR: assert property (PSEL && PENABLE && CPU_STOP |-> PSLVERR)
    else $error("access accepted in power-down");
  AST_HALT: assert property (ENGINE_HALT |-> !ENGINE_CLK_EN && TX_PENDING == 3'b000)
    else $error("halt does not stop traffic");
  // Deferred work waits for wakeup
  AST_NO_COPY: assert property (!ENGINE_CLK_EN |-> !COPY_FG)
    else $error("buffer copy while stopped");
  AST_BO_PAUSE: assert property (!ENGINE_CLK_EN |-> !BUSOFF_COUNT_EN)
    else $error("recovery count runs while stopped");
  // Timer link rises the cycle after a frame and ends at the next bit tick
  AST_LINK_SET: assert property (EOF_DONE && ENGINE_CLK_EN |=> TIMER_LINK)
    else $error("no timer link after frame");
  AST_LINK_RISE: assert property ($rose(TIMER_LINK) |-> $past(EOF_DONE))
    else $error("timer link without frame");
  AST_LINK_END: assert property (TIMER_LINK && BIT_TICK && !EOF_DONE |=> !TIMER_LINK)
    else $error("timer link longer than a bit");
  // Enables are clear out of reset
  AST_IRQ_RST: assert property ($past(RESET) |-> !IRQ_TX && !IRQ_ERROR)
    else $error("request raised from reset");
  cover property (EOF_DONE ##1 TIMER_LINK);
  cover property (!ENGINE_CLK_EN && !ENGINE_HALT);
  cover property (PSLVERR);
endmodule

bind can_irq_power_mode_ctrl can_irq_props u_props (.CLK, .RESET, .PSEL, .PENABLE, .PSLVERR,
  .CPU_STOP, .BIT_TICK, .EOF_DONE, .ENGINE_HALT, .ENGINE_CLK_EN, .COPY_FG, .BUSOFF_COUNT_EN,
  .TX_PENDING, .CAN_TX, .IRQ_TX, .IRQ_ERROR, .TIMER_LINK);

// ---- sim/can_bus_model.sv ----
module can_bus_model (
  // Clock
  input logic clk,
  // Engine events seen on the bus
  output logic bit_tick,
  output logic can_rx,
  output logic busy,
  output logic eof,
  output logic acc,
  output logic own
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] cnt_q;
  initial begin
    cnt_q = 2'h0;
    bit_tick = 1'b0;
    can_rx = 1'b1;
    {busy, eof, acc, own} = 4'h0;
  end
  // Bit clock of the engine, one tick in four cycles
  always @(posedge clk) begin
    cnt_q <= cnt_q + 2'h1;
    bit_tick <= (cnt_q == 2'h3);
  end
  // Whole frame; qualifiers drop to their inverse once released
  task frame(input logic own_f);
    @(posedge clk);
    busy <= 1'b1;
    can_rx <= 1'b0;
    repeat (8) @(posedge clk);
    can_rx <= 1'b1;
    @(posedge clk);
    eof <= 1'b1;
    acc <= 1'b1;
    own <= own_f;
    @(posedge clk);
    eof <= 1'b0;
    acc <= 1'b0;
    own <= ~own_f;
    busy <= 1'b0;
    repeat (12) @(posedge clk);
  endtask
  // Short dominant blip, counts as bus activity
  task blip();
    @(posedge clk);
    can_rx <= 1'b0;
    repeat (2) @(posedge clk);
    can_rx <= 1'b1;
    @(posedge clk);
  endtask
endmodule

// ---- sim/testbench.sv ----
`include "can_irq_consts.svh"
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic CLK, RESET, PSEL, PENABLE, PWRITE, CPU_STOP, RX_ERR_INC, TX_ERR_INC, ENGINE_TX;
  logic [11:0] PADDR;
  logic [31:0] PWDATA, PRDATA, seed, r;
  logic [2:0] TX_DONE, TX_PENDING;
  logic RX_ERR_DEC = 1'b0;
  logic TX_ERR_DEC = 1'b0;
  logic [2:0] TX_ABORT_REQ = 3'h0;
  logic PREADY, PSLVERR, CAN_TX, ENGINE_HALT, ENGINE_CLK_EN, COPY_FG, BUSOFF_COUNT_EN;
  logic IRQ_WAKEUP, IRQ_ERROR, IRQ_RX, IRQ_TX, TIMER_LINK, link_q;
  logic BIT_TICK, CAN_RX, ENGINE_BUSY, EOF_DONE, FRAME_ACCEPTED, OWN_FRAME;
  logic [32:0] exp_q[$];
  int n_mismatch, n_compared, cyc, n_link;

  can_irq_power_mode_ctrl u_dut (.CLK, .RESET, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA,
    .PRDATA, .PREADY, .PSLVERR, .CPU_STOP, .BIT_TICK, .EOF_DONE, .FRAME_ACCEPTED, .OWN_FRAME,
    .ENGINE_BUSY, .TX_DONE, .TX_ABORT_REQ, .RX_ERR_INC, .RX_ERR_DEC, .TX_ERR_INC, .TX_ERR_DEC,
    .CAN_RX, .ENGINE_TX, .CAN_TX, .ENGINE_HALT, .ENGINE_CLK_EN, .TX_PENDING, .COPY_FG,
    .BUSOFF_COUNT_EN, .IRQ_WAKEUP, .IRQ_ERROR, .IRQ_RX, .IRQ_TX, .TIMER_LINK);
  can_bus_model u_bus (.clk(CLK), .bit_tick(BIT_TICK), .can_rx(CAN_RX), .busy(ENGINE_BUSY),
    .eof(EOF_DONE), .acc(FRAME_ACCEPTED), .own(OWN_FRAME));

  always #4 CLK = ~CLK;
  ////////////////////////////////////////
  function logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task final_report();
    $display("mismatches %0d compared %0d", n_mismatch, n_compared);
    if (n_mismatch == 0 && n_compared > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task chk(input logic [32:0] s, input logic [32:0] e);
    n_compared++;
    if (s !== e) begin
      n_mismatch++;
      $display("CHECK FAILED %0t seen %h want %h", $time, s, e);
    end
  endtask
  // Setup, then access held until ready is seen at an edge
  task apb(input logic w, input logic [11:0] a, input logic [7:0] d, input logic [32:0] e);
    @(posedge CLK);
    PSEL <= 1'b1;
    PENABLE <= 1'b0;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= {24'h0, d};
    exp_q.push_back(e);
    @(posedge CLK);
    PENABLE <= 1'b1;
    @(posedge CLK);
    while (PREADY !== 1'b1) @(posedge CLK);
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
    @(negedge CLK);
  endtask
  task wr(input logic [11:0] a, input logic [7:0] d);
    apb(1'b1, a, d, 33'h0);
  endtask
  task rd(input logic [11:0] a, input logic [7:0] d);
    apb(1'b0, a, 8'h0, {25'h0, d});
  endtask
  task errs(input int n, input logic tx);
    repeat (n) begin
      @(posedge CLK);
      RX_ERR_INC <= !tx;
      TX_ERR_INC <= tx;
      @(posedge CLK);
      RX_ERR_INC <= 1'b0;
      TX_ERR_INC <= 1'b0;
    end
  endtask
  task do_reset();
    @(posedge CLK);
    RESET <= 1'b1;
    repeat (12) @(posedge CLK);
    RESET <= 1'b0;
    @(negedge CLK);
  endtask
  task pin(input logic s, input logic e);
    chk({32'h0, s}, {32'h0, e});
  endtask
  ////////////////////////////////////////
  // Completed transfers against the oldest note; data ignored on error
  always @(posedge CLK) begin
    if (PSEL && PENABLE && PREADY === 1'b1 && exp_q.size() > 0)
      chk({PSLVERR, (PSLVERR !== 1'b0 || PWRITE) ? 32'h0 : PRDATA}, exp_q.pop_front());
    link_q <= TIMER_LINK;
    if (TIMER_LINK === 1'b1 && !link_q)
      n_link++;
    cyc++;
    // Whole run needs under 3000 cycles
    if (cyc > 8000) begin
      n_mismatch++;
      final_report();
    end
  end

  initial begin
    {CLK, RESET, PSEL, PENABLE, PWRITE, CPU_STOP, RX_ERR_INC, TX_ERR_INC, ENGINE_TX} = 9'h081;
    {PADDR, PWDATA, TX_DONE, link_q} = 48'h0;
    seed = 32'h8DB2;
    {n_mismatch, n_compared, cyc, n_link} = '0;
    do_reset();
    pin(IRQ_TX | IRQ_RX | IRQ_ERROR | IRQ_WAKEUP, 1'b0);
    pin(CAN_TX, 1'b1);
    rd(`OFF_CTRL0, `CTRL0_RESET_VAL);
    rd(`OFF_TXFLG, 8'h07);
    r = xs();
    wr(`OFF_BTR0, r[7:0]);
    rd(`OFF_BTR0, r[7:0]);
    wr(`OFF_CTRL0, 8'h08);
    wr(`OFF_BTR0, ~r[7:0]);
    rd(`OFF_BTR0, r[7:0]);
    wr(`OFF_RXERR, 8'h55);
    rd(`OFF_RXERR, 8'h00);
    apb(1'b0, 12'h0FC, 8'h00, {1'b1, 32'h0});
    // Transmit empty flags and their request
    wr(`OFF_TXIEN, 8'h02);
    pin(IRQ_TX, 1'b1);
    wr(`OFF_TXFLG, 8'h02);
    chk({30'h0, TX_PENDING}, 33'h2);
    pin(IRQ_TX, 1'b0);
    @(posedge CLK);
    TX_DONE <= 3'b010;
    ENGINE_TX <= r[9];
    @(posedge CLK);
    TX_DONE <= 3'b000;
    @(negedge CLK);
    pin(IRQ_TX, 1'b1);
    pin(CAN_TX, r[9]);
    // Receive, own frames and overrun
    wr(`OFF_RXIEN, 8'h01);
    u_bus.frame(1'b0);
    pin(IRQ_RX, 1'b1);
    u_bus.frame(1'b1);
    rd(`OFF_RXFLG, 8'h01);
    chk({1'b0, 32'(n_link)}, 33'h2);
    u_bus.frame(1'b0);
    u_bus.frame(1'b0);
    rd(`OFF_RXFLG, 8'h03);
    wr(`OFF_RXFLG, 8'h03);
    rd(`OFF_RXFLG, 8'h01);
    wr(`OFF_RXFLG, 8'h01);
    rd(`OFF_RXFLG, 8'h00);
    // Error counter thresholds
    wr(`OFF_RXIEN, 8'h04);
    errs(96, 1'b0);
    rd(`OFF_RXFLG, 8'h40);
    rd(`OFF_RXERR, 8'h60);
    errs(32, 1'b0);
    rd(`OFF_RXFLG, 8'h50);
    wr(`OFF_RXFLG, 8'h50);
    rd(`OFF_RXFLG, 8'h50);
    pin(IRQ_ERROR, 1'b0);
    errs(256, 1'b1);
    rd(`OFF_RXFLG, 8'h7C);
    pin(IRQ_ERROR, 1'b1);
    // Sleep, wake on activity, then power-down
    do_reset();
    wr(`OFF_CTRL0, 8'h08);
    wr(`OFF_RXIEN, 8'h80);
    wr(`OFF_CTRL0, 8'h0A);
    rd(`OFF_CTRL0, 8'h0E);
    rd(`OFF_STATUS, 8'h09);
    pin(CAN_TX, 1'b1);
    u_bus.blip();
    pin(IRQ_WAKEUP, 1'b1);
    rd(`OFF_CTRL0, 8'h08);
    @(posedge CLK);
    CPU_STOP <= 1'b1;
    ENGINE_TX <= 1'b0;
    apb(1'b1, `OFF_CTRL0, 8'h00, {1'b1, 32'h0});
    pin(CAN_TX, 1'b1);
    @(posedge CLK);
    CPU_STOP <= 1'b0;
    rd(`OFF_CTRL0, 8'h08);
    final_report();
  end
endmodule
